// file: otc_cfg.svh
`ifndef OTC_CFG_SVH
`define OTC_CFG_SVH

// ----------------------------------------------------------------
// Register indices; APB byte address is index times four
// ----------------------------------------------------------------
`define OTC_IDX_TRIM_SEL 12'hff6
`define OTC_IDX_TRIM_VAL 12'hff7
`define OTC_IDX_OPT_STAT 12'hff8
`define OTC_IDX_LOADER 12'hff9
`define OTC_ADDR_W 14

// ----------------------------------------------------------------
// Option byte fields
// ----------------------------------------------------------------
`define OTC_OPT_PIN_FN 7
`define OTC_OPT_LPD_N 6
`define OTC_OPT_RSVD 5
`define OTC_OPT_PAIR2 4
`define OTC_OPT_PAIR1 3
`define OTC_OPT_PAIR0 2
`define OTC_OPT_HI_IDLE 1
`define OTC_OPT_LO_IDLE 0

// ----------------------------------------------------------------
// Trim store
// ----------------------------------------------------------------
`define OTC_TRIM_DEPTH 32
`define OTC_TRIM_LAST 5'h1f
`define OTC_TRIM_LOC_HI 5'h01
`define OTC_TRIM_LOC_LO 5'h02
`define OTC_INFO_BASE 16'h0020
`define OTC_INFO_AW 16
`define OTC_OPT_PM_ADDR 16'h0001
`define OTC_SEL_RESET 8'h00
`define OTC_VAL_RESET 8'h00

`endif

// file: otc_pkg.sv
package otc_pkg;
    typedef enum logic [1:0] {
        OTC_FETCH_OPT,
        OTC_FETCH_TRIM,
        OTC_READY
    } otc_load_state_t;
endpackage : otc_pkg

// file: otc_option_trim.sv
`timescale 1ns/1ns
`include "otc_cfg.svh"

// Function
// - Bit7 selects fault-zero or reset pin function
// - Bit6 low disables low power divide
// - Bit4 high tristates PWM pair 2
// - Bit3 high tristates PWM pair 1
// - Bit2 high tristates PWM pair 0
// - Bit1 sets high-side idle polarity
// - Bit0 sets low-side idle polarity
// - Idle level shared by output control, fault
// - Select register picks trim location 00-1F
// - Value register carries selected trim byte
// - Trim working values reload after reset, STOP
// - Trim writes never touch flash copy
// - Location1 bits 5:0 are temperature trim
// - Location1 supplies frequency trim bits 9:8
// - Location2 holds frequency trim bits 7:0
// - Reloads come from info bytes 21h, 22h
// - 32 locations, read/write working value
// - Option byte fetched at reset only
module otc_option_trim (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`OTC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Nonvolatile memory read port (option byte and info page)
    output logic nvm_req,
    output logic nvm_info,
    output logic [`OTC_INFO_AW-1:0] nvm_addr,
    input wire logic nvm_ack,
    input wire logic [7:0] nvm_rdata,
    // STOP mode recovery pulse
    input wire logic stop_recover,
    // Decoded option outputs
    output logic pin_function_select,
    output logic low_power_divide_disable_n,
    output logic pair2_tristate,
    output logic pair1_tristate,
    output logic pair0_tristate,
    output logic high_side_idle_level,
    output logic low_side_idle_level,
    output logic load_done,
    // Oscillator trim outputs
    output logic [9:0] osc_frequency_trim,
    output logic [5:0] osc_temp_trim
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    otc_pkg::otc_load_state_t state;
    otc_pkg::otc_load_state_t next_state;
    logic [7:0] opt_byte;
    logic [7:0] trim_sel;
    logic [7:0] trim_mem [`OTC_TRIM_DEPTH];
    logic [4:0] fetch_idx;
    logic opt_valid;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic [`OTC_ADDR_W-1:0] addr_sel = {`OTC_IDX_TRIM_SEL, 2'b00};
    wire logic [`OTC_ADDR_W-1:0] addr_val = {`OTC_IDX_TRIM_VAL, 2'b00};
    wire logic [`OTC_ADDR_W-1:0] addr_stat = {`OTC_IDX_OPT_STAT, 2'b00};
    wire logic [`OTC_ADDR_W-1:0] addr_ldr = {`OTC_IDX_LOADER, 2'b00};
    wire logic hit_sel = paddr == addr_sel;
    wire logic hit_val = paddr == addr_val;
    wire logic hit_stat = paddr == addr_stat;
    wire logic hit_ldr = paddr == addr_ldr;
    wire logic hit_any = hit_sel || hit_val || hit_stat || hit_ldr;
    wire logic bus_ok = state == otc_pkg::OTC_READY;
    wire logic wr_ok = access && pready && !pslverr && pwrite && bus_ok;
    wire logic wr_sel = wr_ok && hit_sel;
    wire logic wr_val = wr_ok && hit_val;
    wire logic [4:0] sel_idx = trim_sel[4:0];
    wire logic sel_in_range = trim_sel <= {3'b000, `OTC_TRIM_LAST};
    wire logic [7:0] val_rd = sel_in_range ? trim_mem[sel_idx] : 8'h00;
    wire logic [7:0] rd_byte = hit_sel ? trim_sel :
                               hit_val ? val_rd :
                               hit_stat ? opt_byte :
                               {7'h00, bus_ok};
    wire logic bad = !hit_any || (pwrite && (hit_stat || hit_ldr)) || !bus_ok;

    // ------------------------------------------------------------
    // Loader sequencing
    // ------------------------------------------------------------
    wire logic fetch_done = nvm_req && nvm_ack;
    wire logic last_fetch = fetch_idx == `OTC_TRIM_LAST;
    always_comb begin
        next_state = state;
        unique case (state)
            otc_pkg::OTC_FETCH_OPT: begin
                if (fetch_done) begin
                    next_state = otc_pkg::OTC_FETCH_TRIM;
                end
            end
            otc_pkg::OTC_FETCH_TRIM: begin
                if (fetch_done && last_fetch) begin
                    next_state = otc_pkg::OTC_READY;
                end
            end
            otc_pkg::OTC_READY: begin
                if (stop_recover) begin
                    next_state = otc_pkg::OTC_FETCH_TRIM;
                end
            end
        endcase
    end

    wire logic [`OTC_INFO_AW-1:0] info_addr = `OTC_INFO_BASE + {11'h000, fetch_idx};
    wire logic next_req = next_state != otc_pkg::OTC_READY;
    wire logic next_info = next_state == otc_pkg::OTC_FETCH_TRIM;
    wire logic [4:0] next_idx = (state == otc_pkg::OTC_FETCH_TRIM && fetch_done) ?
                                fetch_idx + 5'h01 :
                                (state == otc_pkg::OTC_READY ? 5'h00 : fetch_idx);
    wire logic [`OTC_INFO_AW-1:0] next_info_addr = `OTC_INFO_BASE + {11'h000, next_idx};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= otc_pkg::OTC_FETCH_OPT;
            fetch_idx <= 5'h00;
            nvm_req <= 1'b1;
            nvm_info <= 1'b0;
            nvm_addr <= `OTC_OPT_PM_ADDR;
        end else begin
            state <= next_state;
            fetch_idx <= next_idx;
            nvm_req <= next_req;
            nvm_info <= next_info;
            nvm_addr <= next_info ? next_info_addr : `OTC_OPT_PM_ADDR;
        end
    end

    // ------------------------------------------------------------
    // Option byte: latched only during the reset fetch
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            opt_valid <= 1'b0;
            opt_byte <= 8'h00;
        end else if (state == otc_pkg::OTC_FETCH_OPT && fetch_done) begin
            opt_valid <= 1'b1;
            opt_byte <= nvm_rdata;
        end
    end

    // Safe idle until fetched: fault-zero, pairs tristated, idle low
    always_ff @(posedge clk_sys) begin
        if (rst || !opt_valid) begin
            pin_function_select <= 1'b0;
            low_power_divide_disable_n <= 1'b1;
            pair2_tristate <= 1'b1;
            pair1_tristate <= 1'b1;
            pair0_tristate <= 1'b1;
            high_side_idle_level <= 1'b0;
            low_side_idle_level <= 1'b0;
        end else begin
            pin_function_select <= opt_byte[`OTC_OPT_PIN_FN];
            low_power_divide_disable_n <= opt_byte[`OTC_OPT_LPD_N];
            pair2_tristate <= opt_byte[`OTC_OPT_PAIR2];
            pair1_tristate <= opt_byte[`OTC_OPT_PAIR1];
            pair0_tristate <= opt_byte[`OTC_OPT_PAIR0];
            high_side_idle_level <= opt_byte[`OTC_OPT_HI_IDLE];
            low_side_idle_level <= opt_byte[`OTC_OPT_LO_IDLE];
        end
    end

    // ------------------------------------------------------------
    // Trim working store; flash is only ever read
    // ------------------------------------------------------------
    wire logic ld_trim = state == otc_pkg::OTC_FETCH_TRIM && fetch_done;
    genvar gi;
    generate
        for (gi = 0; gi < `OTC_TRIM_DEPTH; gi++) begin : g_trim
            wire logic ld_here = ld_trim && fetch_idx == 5'(gi);
            wire logic wr_here = wr_val && sel_in_range && sel_idx == 5'(gi);
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    trim_mem[gi] <= 8'h00;
                end else if (ld_here) begin
                    trim_mem[gi] <= nvm_rdata;
                end else if (wr_here) begin
                    trim_mem[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trim_sel <= `OTC_SEL_RESET;
            osc_frequency_trim <= 10'h000;
            osc_temp_trim <= 6'h00;
        end else begin
            if (wr_sel) begin
                trim_sel <= pwdata[7:0];
            end
            osc_frequency_trim <= {trim_mem[`OTC_TRIM_LOC_HI][7:6],
                                   trim_mem[`OTC_TRIM_LOC_LO]};
            osc_temp_trim <= trim_mem[`OTC_TRIM_LOC_HI][5:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_done <= 1'b0;
        end else begin
            load_done <= next_state == otc_pkg::OTC_READY;
        end
    end

    // ------------------------------------------------------------
    // APB answer: ready in the access cycle, writes land with it
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && bad;
            prdata <= (setup && !pwrite && !bad) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pin_fn;
        @(posedge clk_sys) disable iff (rst)
        opt_valid && $stable(opt_valid) |=> pin_function_select == opt_byte[`OTC_OPT_PIN_FN];
    endproperty
    a_pin_fn: assert property (p_pin_fn) else $error("pin function mismatch");

    property p_lpd;
        @(posedge clk_sys) disable iff (rst)
        opt_valid |=> low_power_divide_disable_n == $past(opt_byte[`OTC_OPT_LPD_N]);
    endproperty
    a_lpd: assert property (p_lpd) else $error("low power divide mismatch");

    property p_pair2;
        @(posedge clk_sys) disable iff (rst)
        opt_valid |=> pair2_tristate == $past(opt_byte[`OTC_OPT_PAIR2]);
    endproperty
    a_pair2: assert property (p_pair2) else $error("pair2 mismatch");

    property p_pair1;
        @(posedge clk_sys) disable iff (rst)
        !opt_valid |=> pair1_tristate && pair0_tristate;
    endproperty
    a_pair1: assert property (p_pair1) else $error("pairs not safe before load");

    property p_pair0;
        @(posedge clk_sys) disable iff (rst)
        opt_valid |=> pair0_tristate == $past(opt_byte[`OTC_OPT_PAIR0]);
    endproperty
    a_pair0: assert property (p_pair0) else $error("pair0 mismatch");

    property p_idle;
        @(posedge clk_sys) disable iff (rst)
        opt_valid |=> high_side_idle_level == $past(opt_byte[`OTC_OPT_HI_IDLE])
                    && low_side_idle_level == $past(opt_byte[`OTC_OPT_LO_IDLE]);
    endproperty
    a_idle: assert property (p_idle) else $error("idle level mismatch");

    property p_opt_frozen;
        @(posedge clk_sys) disable iff (rst)
        opt_valid |=> $stable(opt_byte);
    endproperty
    a_opt_frozen: assert property (p_opt_frozen) else $error("option byte changed");

    property p_trim_wr;
        @(posedge clk_sys) disable iff (rst)
        wr_val && sel_in_range && !stop_recover |=> trim_mem[$past(sel_idx)] == $past(pwdata[7:0]);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");

    property p_freq;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> osc_frequency_trim == {$past(trim_mem[`OTC_TRIM_LOC_HI][7:6]),
                                        $past(trim_mem[`OTC_TRIM_LOC_LO])};
    endproperty
    a_freq: assert property (p_freq) else $error("frequency trim mismatch");

    property p_reload;
        @(posedge clk_sys) disable iff (rst)
        state == otc_pkg::OTC_READY && stop_recover |=> nvm_req && nvm_info
            && nvm_addr == `OTC_INFO_BASE;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload after stop");

    property p_sel_rd;
        @(posedge clk_sys) disable iff (rst)
        setup && !pwrite && hit_sel && bus_ok |=> pready && prdata[7:0] == $past(trim_sel);
    endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("select readback wrong");

    property p_pair1_map;
        @(posedge clk_sys) disable iff (rst)
        opt_valid |=> pair1_tristate == $past(opt_byte[`OTC_OPT_PAIR1]);
    endproperty
    a_pair1_map: assert property (p_pair1_map) else $error("pair1 mismatch");

    property p_safe_idle;
        @(posedge clk_sys) disable iff (rst)
        !opt_valid |=> !pin_function_select && low_power_divide_disable_n && pair2_tristate
            && !high_side_idle_level && !low_side_idle_level;
    endproperty
    a_safe_idle: assert property (p_safe_idle) else $error("outputs not safe before load");

    property p_load_order;
        @(posedge clk_sys) disable iff (rst)
        state == otc_pkg::OTC_FETCH_OPT |-> nvm_req && !nvm_info
            && nvm_addr == `OTC_OPT_PM_ADDR;
    endproperty
    a_load_order: assert property (p_load_order) else $error("option byte not fetched first");

    property p_info_addr;
        @(posedge clk_sys) disable iff (rst)
        nvm_info |-> nvm_req && nvm_addr == info_addr;
    endproperty
    a_info_addr: assert property (p_info_addr) else $error("info page address wrong");

    property p_trim_reload;
        @(posedge clk_sys) disable iff (rst)
        ld_trim |=> trim_mem[$past(fetch_idx)] == $past(nvm_rdata);
    endproperty
    a_trim_reload: assert property (p_trim_reload) else $error("reload byte lost");

    property p_temp;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> osc_temp_trim == $past(trim_mem[`OTC_TRIM_LOC_HI][5:0]);
    endproperty
    a_temp: assert property (p_temp) else $error("temperature trim mismatch");

    property p_val_rd;
        @(posedge clk_sys) disable iff (rst)
        setup && !pwrite && hit_val && bus_ok && sel_in_range
            |=> pready && prdata[7:0] == $past(trim_mem[sel_idx]);
    endproperty
    a_val_rd: assert property (p_val_rd) else $error("value readback wrong");

    property p_wr_sel;
        @(posedge clk_sys) disable iff (rst)
        wr_sel |=> trim_sel == $past(pwdata[7:0]);
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("select write lost");

    property p_early_err;
        @(posedge clk_sys) disable iff (rst)
        setup && !bus_ok |=> pready && pslverr;
    endproperty
    a_early_err: assert property (p_early_err) else $error("access before load not refused");

    property p_rd_idle;
        @(posedge clk_sys) disable iff (rst)
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");

    c_load: cover property (@(posedge clk_sys) disable iff (rst) $rose(load_done));
    c_stop: cover property (@(posedge clk_sys) disable iff (rst)
        state == otc_pkg::OTC_READY && stop_recover);
    c_wr: cover property (@(posedge clk_sys) disable iff (rst) wr_val && sel_in_range);
    c_err: cover property (@(posedge clk_sys) disable iff (rst) pready && pslverr);

endmodule : otc_option_trim

// file: otc_nvm_model.sv
`timescale 1ns/1ns
module otc_nvm_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Read port
    input wire logic nvm_req,
    input wire logic nvm_info,
    input wire logic [15:0] nvm_addr,
    output logic nvm_ack,
    output logic [7:0] nvm_rdata,
    // Contents and pacing
    input wire logic [7:0] opt_byte,
    input wire logic [3:0] wait_cycles
);
    logic [3:0] wait_cnt;
    logic [7:0] word;
    logic [7:0] info_word;
    // Info page is never written from the bus side
    assign info_word = 8'ha5 ^ {3'h0, nvm_addr[4:0]};
    // Reserved bit kept at one by the programmer
    assign word = nvm_info ? info_word : (opt_byte | 8'h20);
    // Data line toggles whenever no byte is offered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nvm_ack <= 1'b0;
            wait_cnt <= 4'h0;
            nvm_rdata <= 8'h5a;
        end else if (!nvm_req || nvm_ack) begin
            nvm_ack <= 1'b0;
            wait_cnt <= 4'h0;
            nvm_rdata <= ~nvm_rdata;
        end else if (wait_cnt == wait_cycles) begin
            nvm_ack <= 1'b1;
            nvm_rdata <= word;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
            nvm_rdata <= ~nvm_rdata;
        end
    end
endmodule : otc_nvm_model

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [13:0] A_SEL = 14'h3fd8;
    localparam logic [13:0] A_VAL = 14'h3fdc;
    localparam logic [13:0] A_STAT = 14'h3fe0;
    localparam logic [13:0] A_LDR = 14'h3fe4;
    logic clk_sys, rst, psel, penable, pwrite, stop_recover;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, nvm_req, nvm_info, nvm_ack, load_done;
    logic [15:0] nvm_addr;
    logic [7:0] nvm_rdata, opt_byte;
    logic [3:0] wait_cycles;
    logic pfs, lpd, t2, t1, t0, hi_idle, lo_idle;
    logic [9:0] osc_frequency_trim;
    logic [5:0] osc_temp_trim;
    logic [7:0] opt_tab [2] = '{8'h2a, 8'hf5};
    int miscompares = 0;
    int cmp_count = 0;

    otc_option_trim u_otc_option_trim (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_req(nvm_req),
        .nvm_info(nvm_info), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack),
        .nvm_rdata(nvm_rdata), .stop_recover(stop_recover), .pin_function_select(pfs),
        .low_power_divide_disable_n(lpd), .pair2_tristate(t2), .pair1_tristate(t1),
        .pair0_tristate(t0), .high_side_idle_level(hi_idle),
        .low_side_idle_level(lo_idle), .load_done(load_done),
        .osc_frequency_trim(osc_frequency_trim), .osc_temp_trim(osc_temp_trim));
    otc_nvm_model u_otc_nvm_model (.clk_sys(clk_sys), .rst(rst), .nvm_req(nvm_req),
        .nvm_info(nvm_info), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack),
        .nvm_rdata(nvm_rdata), .opt_byte(opt_byte), .wait_cycles(wait_cycles));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // APB master: setup, access, hold until pready
    task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wait_done();
        int i;
        for (i = 0; i < 500 && load_done !== 1'b1; i++) @(posedge clk_sys);
        if (i == 500) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : wait_done

    task automatic check_opts(input logic [7:0] o);
        chk("pin_fn", o[7], pfs);
        chk("lpd", o[6], lpd);
        chk("pair2", o[4], t2);
        chk("pair1", o[3], t1);
        chk("pair0", o[2], t0);
        chk("hi_idle", o[1], hi_idle);
        chk("lo_idle", o[0], lo_idle);
    endtask : check_opts

    task automatic check_trims(input logic [7:0] hi, input logic [7:0] lo);
        chk("freq", {hi[7:6], lo}, osc_frequency_trim);
        chk("temp", hi[5:0], osc_temp_trim);
    endtask : check_trims

    initial begin
        {psel, penable, pwrite, stop_recover} = 4'h0;
        paddr = 14'h0;
        pwdata = 32'h0;
        rst = 1'b1;
        for (int p = 0; p < 2; p++) begin
            opt_byte <= opt_tab[p];
            wait_cycles <= (p == 0) ? 4'h0 : 4'h3;
            rst <= 1'b1;
            repeat (20) @(posedge clk_sys);
            rst <= 1'b0;
            xfer(1'b0, A_SEL, 32'h0);
            chk("early_err", 1'b1, er);
            wait_done();
            check_opts(opt_tab[p]);
            check_trims(8'ha4, 8'ha7);
        end
        xfer(1'b0, A_SEL, 32'h0);
        chk("sel_rst", 32'h0, rd);
        xfer(1'b0, A_VAL, 32'h0);
        chk("val0", 32'ha5, rd);
        xfer(1'b1, A_SEL, 32'h1f);
        xfer(1'b0, A_VAL, 32'h0);
        chk("val1f", 32'hba, rd);
        xfer(1'b1, A_VAL, 32'h5c);
        xfer(1'b0, A_VAL, 32'h0);
        chk("val1f_wr", 32'h5c, rd);
        xfer(1'b1, A_SEL, 32'h20);
        xfer(1'b0, A_VAL, 32'h0);
        chk("val_oob", 32'h0, rd);
        xfer(1'b1, A_SEL, 32'h2);
        xfer(1'b1, A_VAL, 32'h3c);
        xfer(1'b1, A_SEL, 32'h1);
        xfer(1'b1, A_VAL, 32'h7f);
        repeat (2) @(posedge clk_sys);
        check_trims(8'h7f, 8'h3c);
        xfer(1'b0, A_LDR, 32'h0);
        chk("ldr", 1'b1, rd[0]);
        xfer(1'b0, 14'h0100, 32'h0);
        chk("unmapped", 1'b1, er);
        xfer(1'b1, A_STAT, 32'hff);
        chk("ro_wr", 1'b1, er);
        // Option source changes without a reset: outputs must not follow
        opt_byte <= opt_tab[0];
        stop_recover <= 1'b1;
        @(posedge clk_sys);
        stop_recover <= 1'b0;
        repeat (2) @(posedge clk_sys);
        wait_done();
        check_trims(8'ha4, 8'ha7);
        check_opts(opt_tab[1]);
        xfer(1'b1, A_SEL, 32'h1f);
        xfer(1'b0, A_VAL, 32'h0);
        chk("reload1f", 32'hba, rd);
        tally_and_finish();
    end
endmodule : testbench
